// [dv/cfs_mem_model.sv]
// data memory model behind the indirect data port
`timescale 1ns/1ns
module cfs_mem_model (
    // clock
    input wire logic pclk,
    // memory side
    input wire logic [8:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_q [512];
    logic [7:0] last_q;
    // preset pattern from the low eight address bits, so both banks read back the same
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem_q[i] = i[7:0] ^ 8'h5A;
        end
        last_q = 8'h00;
    end
    always @(posedge pclk) begin
        if (mem_we) begin
            mem_q[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            last_q <= mem_q[mem_addr];
        end
    end
    // released bus shows the inverse of the last value, never a stale copy
    assign mem_rdata = mem_re ? mem_q[mem_addr] : ~last_q;
endmodule

// [dv/core_flow_and_status_regs_tb.sv]
// self-checking testbench for the core flow and status block
`timescale 1ns/1ns
module core_flow_and_status_regs_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng;
    logic [3:0] pstrb;
    logic po_ev, bo_ev, add_v, mem_we, mem_re, ulw_en, bod_en;
    logic [1:0] bod_cfg;
    cfs_pkg::cfs_periph_t periph;
    cfs_pkg::cfs_flow_req_t flow_req;
    logic [7:0] add_off, mem_rdata, mem_wdata, r, cmp_lvl;
    logic [8:0] mem_addr;
    logic [12:0] pc, stack_top, pc_m;
    logic [12:0] stk [8];
    logic [32:0] expq [$];
    int errors, num_checks, we_count, sp, n;

    cfs_core #(.STACK_N(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_on_event(po_ev),
        .brownout_event(bo_ev), .brownout_config_field(bod_cfg), .periph(periph),
        .flow_req(flow_req), .pc_add_offset(add_off), .pc_add_valid(add_v),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_re(mem_re), .program_counter(pc), .stack_top(stack_top),
        .ultra_low_wake_enable(ulw_en), .brownout_detect_enable(bod_en));

    cfs_mem_model mem (.pclk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (expq.size() != 0) errors++;
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // read notes its expectation before the access; the monitor compares
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) expq.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        apb(1'b0, a, 32'h0, exp);
    endtask

    task automatic flow(input cfs_pkg::cfs_op_t op, input logic [10:0] t, input logic [12:0] v);
        @(posedge pclk);
        flow_req <= '{op: op, target: t, vector: v};
        @(posedge pclk);
        flow_req <= '{op: cfs_pkg::CFS_OP_NONE, target: 11'h0, vector: 13'h0};
    endtask

    always @(posedge pclk) begin
        if (mem_we === 1'b1) we_count++;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (expq.size() > 0) begin
                chk("read data", {pslverr, prdata}, expq.pop_front());
            end else begin
                errors++;
                $display("CHECK FAILED read without note expected none seen %h", prdata);
            end
        end
    end

    // generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        complete_run();
    end

    initial begin
        {presetn, psel, penable, pwrite, po_ev, bo_ev, add_v} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        bod_cfg = 2'h1;
        periph = '0;
        flow_req = '0;
        add_off = 8'h0;
        rng = 32'h0001_1373;
        {errors, num_checks, we_count, sp} = '0;
        cmp_lvl = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(cfs_pkg::ADDR_REQ_FLAGS, {25'h0, cfs_pkg::REQ_RESET});
        rd(cfs_pkg::ADDR_POWER_CTL, {25'h0, cfs_pkg::POWER_CONTROL_STATUS_RESET});
        chk("brownout enable", {32'h0, bod_en}, 33'h1);
        rd(12'h7F0, {1'b1, cfs_pkg::UNMAPPED_DATA});
        // sticky events pulse, comparators toggle, buffer levels hold
        for (int i = 0; i < 5; i++) begin
            void'(next_rand());
            r = (i == 0) ? 8'hFF : rng[7:0];
            cmp_lvl = cmp_lvl ^ (r & 8'h18);
            @(posedge pclk);
            periph <= cfs_pkg::cfs_periph_t'((r & 8'hC5) | cmp_lvl | (r & 8'h22));
            @(posedge pclk);
            periph <= cfs_pkg::cfs_periph_t'(cmp_lvl | (r & 8'h22));
            repeat (3) @(posedge pclk);
            rd(cfs_pkg::ADDR_REQ_FLAGS, {25'h0, r});
            wr(cfs_pkg::ADDR_REQ_FLAGS, 32'h0);
            rd(cfs_pkg::ADDR_REQ_FLAGS, {25'h0, r & 8'h22});
        end
        wr(cfs_pkg::ADDR_POWER_CTL, 32'hFF);
        rd(cfs_pkg::ADDR_POWER_CTL, {25'h0, cfs_pkg::POWER_CONTROL_STATUS_WMASK});
        chk("wake enable", {32'h0, ulw_en}, 33'h1);
        bod_cfg <= 2'h2;
        repeat (2) @(posedge pclk);
        chk("brownout enable", {32'h0, bod_en}, 33'h0);
        bo_ev <= 1'b1;
        @(posedge pclk);
        bo_ev <= 1'b0;
        rd(cfs_pkg::ADDR_POWER_CTL, 33'h32);
        po_ev <= 1'b1;
        @(posedge pclk);
        po_ev <= 1'b0;
        rd(cfs_pkg::ADDR_POWER_CTL, 33'h30);
        wr(cfs_pkg::ADDR_POWER_CTL, 32'h0);
        rd(cfs_pkg::ADDR_POWER_CTL, 33'h0);
        chk("wake enable", {32'h0, ulw_en}, 33'h0);
        wr(cfs_pkg::ADDR_LATCH, 32'h1A);
        wr(cfs_pkg::ADDR_PC_LOW, 32'h34);
        rd(cfs_pkg::ADDR_PC_FULL, 33'h1A34);
        rd(cfs_pkg::ADDR_PC_LOW, 33'h34);
        add_off <= 8'hF0;
        add_v <= 1'b1;
        @(posedge pclk);
        add_v <= 1'b0;
        rd(cfs_pkg::ADDR_PC_FULL, 33'h1A24);
        wr(cfs_pkg::ADDR_LATCH, 32'h18);
        flow(cfs_pkg::CFS_OP_JUMP, 11'h123, 13'h0);
        pc_m = 13'h1923;
        rd(cfs_pkg::ADDR_PC_FULL, {20'h0, pc_m});
        chk("program counter", {20'h0, pc}, {20'h0, pc_m});
        // ten pushes: the last two overwrite the oldest entries
        for (int i = 0; i < 10; i++) begin
            stk[sp] = pc_m + 13'h1;
            sp = (sp + 1) % 8;
            if (i == 0) begin
                flow(cfs_pkg::CFS_OP_VECTOR, 11'h0, 13'h0004);
                pc_m = 13'h0004;
            end else begin
                flow(cfs_pkg::CFS_OP_CALL, 11'h100 + 11'(i), 13'h0);
                pc_m = {2'b11, 11'h100 + 11'(i)};
            end
        end
        repeat (2) @(posedge pclk);
        chk("stack top", {20'h0, stack_top}, {20'h0, stk[(sp + 7) % 8]});
        for (int i = 0; i < 10; i++) begin
            sp = (sp + 7) % 8;
            pc_m = stk[sp];
            flow((i % 3 == 0) ? cfs_pkg::CFS_OP_RETURN :
                 (i % 3 == 1) ? cfs_pkg::CFS_OP_RET_LIT : cfs_pkg::CFS_OP_RET_INT,
                 11'h0, 13'h0);
            rd(cfs_pkg::ADDR_PC_FULL, {20'h0, pc_m});
        end
        chk("stack top", {20'h0, stack_top}, {20'h0, stk[(sp + 7) % 8]});
        // call and return back to back, then a plain step
        @(posedge pclk);
        flow_req <= '{op: cfs_pkg::CFS_OP_CALL, target: 11'h055, vector: 13'h0};
        @(posedge pclk);
        flow_req <= '{op: cfs_pkg::CFS_OP_RETURN, target: 11'h0, vector: 13'h0};
        @(posedge pclk);
        flow_req <= '0;
        rd(cfs_pkg::ADDR_PC_FULL, {20'h0, pc_m + 13'h1});
        flow(cfs_pkg::CFS_OP_STEP, 11'h0, 13'h0);
        rd(cfs_pkg::ADDR_PC_FULL, {20'h0, pc_m + 13'h2});
        rd(cfs_pkg::ADDR_LATCH, 33'h18);
        // low byte lane disabled: the write must be ignored
        pstrb <= 4'hE;
        wr(cfs_pkg::ADDR_LATCH, 32'h07);
        pstrb <= 4'hF;
        rd(cfs_pkg::ADDR_LATCH, 33'h18);
        wr(cfs_pkg::ADDR_POINTER, 32'h45);
        wr(cfs_pkg::ADDR_STATUS_CTL, 32'h1);
        n = we_count;
        wr(cfs_pkg::ADDR_INDIRECT, 32'hA5);
        repeat (3) @(posedge pclk);
        chk("memory writes", 33'(we_count), 33'(n + 1));
        rd(cfs_pkg::ADDR_INDIRECT, 33'hA5);
        wr(cfs_pkg::ADDR_STATUS_CTL, 32'h0);
        rd(cfs_pkg::ADDR_INDIRECT, 33'h1F);
        wr(cfs_pkg::ADDR_POINTER, 32'h0);
        rd(cfs_pkg::ADDR_INDIRECT, {25'h0, cfs_pkg::INDIRECT_SELF});
        n = we_count;
        wr(cfs_pkg::ADDR_INDIRECT, 32'h77);
        repeat (3) @(posedge pclk);
        chk("memory writes", 33'(we_count), 33'(n));
        repeat (2) @(posedge pclk);
        complete_run();
    end
endmodule

// [verilog/cfs_core.sv]
// core flow control, request flags, power status, return stack and indirect addressing
`timescale 1ns/1ns
// Summary of operation
// - nonvolatile write completion sets request bit 7; software writes zero to clear.
// - conversion completion sets request bit 6; zero until a conversion completes.
// - bit 5 read-only, one while receive buffer holds data.
// - bit 1 read-only, one while transmit buffer is empty.
// - comparator output changes set bits 4 and 3, held until cleared.
// - oscillator failure sets bit 2, held until software clears it.
// - timer one overflow sets bit 0, held until software clears it.
// - power bit 5 enables ultra low-power wake-up; resets to zero.
// - power bit 4 enables brown-out detect only when config field is 01.
// - power-on reset clears power bit 1; software sets it afterwards.
// - brown-out detection clears power bit 0; software sets it afterwards.
// - counter is 13 bits, cleared on reset; low byte is writable, full value is read-only at ADDR_PC_FULL.
// - low-byte write loads upper five bits from latch bits 4 to 0.
// - call or jump takes counter top two bits from latch bits 4 and 3.
// - eight-entry 13-bit return stack, pointer hidden from software.
// - call or interrupt vector pushes the counter plus one.
// - return variants pop the stack; latch never changed by push or pop.
// - stack wraps circularly; ninth push overwrites the first entry.
// - no overflow or underflow indication; wrapping is silent.
// - indirect port accesses the location chosen by the file pointer.
// - indirect access to the port itself reads 00h and writes nothing.
// - indirect address is bank select bit above eight-bit file pointer.
module cfs_core #(
    parameter int STACK_N = 8
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset causes and configuration
    input wire logic power_on_event,
    input wire logic brownout_event,
    input wire logic [1:0] brownout_config_field,
    // peripheral status
    input wire cfs_pkg::cfs_periph_t periph,
    // execution unit
    input wire cfs_pkg::cfs_flow_req_t flow_req,
    input wire logic [7:0] pc_add_offset,
    input wire logic pc_add_valid,
    // indirect data memory side
    input wire logic [7:0] mem_rdata,
    output logic [8:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    // program counter and power outputs
    output logic [12:0] program_counter,
    output logic [12:0] stack_top,
    output logic ultra_low_wake_enable,
    output logic brownout_detect_enable
);
    localparam int SP_W = $clog2(STACK_N);

    logic [7:0] req_q;
    logic [7:0] power_control_status_q;
    logic [12:0] pc_q;
    logic [4:0] counter_high_latch_q;
    logic [7:0] file_pointer_q;
    logic indirect_bank_select_q;
    logic [12:0] stack_mem [STACK_N];
    logic [SP_W-1:0] sp_q;
    logic cmp_two_q;
    logic cmp_one_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [8:0] mem_addr_q;
    logic [7:0] mem_wdata_q;
    logic mem_we_q;
    logic mem_re_q;
    logic [12:0] stack_top_q;
    cfs_pkg::cfs_state_t state_q;

    logic setup;
    logic wr_acc;
    logic ind_rd;
    logic ind_wait_q;
    logic bod_en_q;
    logic mapped;
    logic ind_self;
    logic [7:0] req_set;
    logic [7:0] req_view;
    logic [12:0] pc_d;
    logic push;
    logic pop;
    logic [SP_W-1:0] sp_prev;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pready_q && pstrb[0];
    assign ind_rd = !pwrite && paddr == cfs_pkg::ADDR_INDIRECT && !ind_self;
    assign mapped = paddr == cfs_pkg::ADDR_REQ_FLAGS || paddr == cfs_pkg::ADDR_POWER_CTL
        || paddr == cfs_pkg::ADDR_LATCH || paddr == cfs_pkg::ADDR_PC_LOW
        || paddr == cfs_pkg::ADDR_POINTER || paddr == cfs_pkg::ADDR_INDIRECT
        || paddr == cfs_pkg::ADDR_PC_FULL || paddr == cfs_pkg::ADDR_STATUS_CTL;
    assign ind_self = file_pointer_q == cfs_pkg::IDX_REQ_FLAGS - 8'h0C;
    assign sp_prev = sp_q - SP_W'(1);

    // ready in the first access cycle; indirect reads take one more so that
    // memory data is captured in a flop instead of passing straight through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= cfs_pkg::CFS_ST_IDLE;
            pready_q <= 1'b0;
            ind_wait_q <= 1'b0;
        end else begin
            case (state_q)
                cfs_pkg::CFS_ST_IDLE: begin
                    pready_q <= 1'b0;
                    ind_wait_q <= 1'b0;
                    if (setup) begin
                        state_q <= cfs_pkg::CFS_ST_ACCESS;
                        pready_q <= !ind_rd;
                        ind_wait_q <= ind_rd;
                    end
                end
                cfs_pkg::CFS_ST_ACCESS: begin
                    ind_wait_q <= 1'b0;
                    if (ind_wait_q) begin
                        pready_q <= 1'b1;
                    end else begin
                        state_q <= cfs_pkg::CFS_ST_IDLE;
                        pready_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= cfs_pkg::CFS_ST_IDLE;
                    pready_q <= 1'b0;
                    ind_wait_q <= 1'b0;
                end
            endcase
        end
    end

    // request flags: hardware set beats software clear
    always_comb begin
        req_set = '0;
        req_set[cfs_pkg::BIT_NV_DONE] = periph.nv_write_done;
        req_set[cfs_pkg::BIT_CONV_DONE] = periph.conversion_done;
        req_set[cfs_pkg::BIT_CMP2] = periph.cmp_two_out != cmp_two_q;
        req_set[cfs_pkg::BIT_CMP1] = periph.cmp_one_out != cmp_one_q;
        req_set[cfs_pkg::BIT_OSC_FAIL] = periph.osc_failed;
        req_set[cfs_pkg::BIT_TMR1] = periph.timer_one_overflow;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_two_q <= 1'b0;
            cmp_one_q <= 1'b0;
        end else begin
            cmp_two_q <= periph.cmp_two_out;
            cmp_one_q <= periph.cmp_one_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= cfs_pkg::REQ_RESET;
        end else if (wr_acc && paddr == cfs_pkg::ADDR_REQ_FLAGS) begin
            req_q <= ((req_q & ~cfs_pkg::REQ_SW_CLEAR_MASK)
                | (pwdata[7:0] & cfs_pkg::REQ_SW_CLEAR_MASK) | req_set)
                & cfs_pkg::REQ_SW_CLEAR_MASK;
        end else begin
            req_q <= (req_q | req_set) & cfs_pkg::REQ_SW_CLEAR_MASK;
        end
    end

    always_comb begin
        req_view = req_q;
        req_view[cfs_pkg::BIT_RX_FULL] = periph.rx_has_data;
        req_view[cfs_pkg::BIT_TX_EMPTY] = periph.tx_empty;
    end

    // power control; presetn is the power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_status_q <= cfs_pkg::POWER_CONTROL_STATUS_RESET;
        end else begin
            if (wr_acc && paddr == cfs_pkg::ADDR_POWER_CTL) begin
                power_control_status_q <= pwdata[7:0] & cfs_pkg::POWER_CONTROL_STATUS_WMASK;
            end
            if (power_on_event) begin
                power_control_status_q[cfs_pkg::BIT_POR_STAT] <= 1'b0;
            end
            if (brownout_event) begin
                power_control_status_q[cfs_pkg::BIT_BOD_STAT] <= 1'b0;
            end
        end
    end

    // program counter
    always_comb begin
        pc_d = pc_q;
        case (flow_req.op)
            cfs_pkg::CFS_OP_CALL,
            cfs_pkg::CFS_OP_JUMP: pc_d = {counter_high_latch_q[4:3], flow_req.target};
            cfs_pkg::CFS_OP_RETURN,
            cfs_pkg::CFS_OP_RET_LIT,
            cfs_pkg::CFS_OP_RET_INT: pc_d = stack_mem[sp_prev];
            cfs_pkg::CFS_OP_VECTOR: pc_d = flow_req.vector;
            cfs_pkg::CFS_OP_STEP: pc_d = pc_q + 13'h0001;
            default: pc_d = pc_q;
        endcase
        if (pc_add_valid) begin
            pc_d = {counter_high_latch_q, 8'(pc_q[7:0] + pc_add_offset)};
        end
        if (wr_acc && paddr == cfs_pkg::ADDR_PC_LOW) begin
            pc_d = {counter_high_latch_q, pwdata[7:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_high_latch_q <= '0;
            file_pointer_q <= '0;
            indirect_bank_select_q <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == cfs_pkg::ADDR_LATCH) begin
                counter_high_latch_q <= pwdata[4:0];
            end
            if (paddr == cfs_pkg::ADDR_POINTER) begin
                file_pointer_q <= pwdata[7:0];
            end
            if (paddr == cfs_pkg::ADDR_STATUS_CTL) begin
                indirect_bank_select_q <= pwdata[0];
            end
        end
    end

    // return stack: hidden pointer, silent wrap
    assign push = flow_req.op == cfs_pkg::CFS_OP_CALL
        || flow_req.op == cfs_pkg::CFS_OP_VECTOR;
    assign pop = flow_req.op == cfs_pkg::CFS_OP_RETURN
        || flow_req.op == cfs_pkg::CFS_OP_RET_LIT
        || flow_req.op == cfs_pkg::CFS_OP_RET_INT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= '0;
        end else if (push) begin
            sp_q <= sp_q + SP_W'(1);
        end else if (pop) begin
            sp_q <= sp_prev;
        end
    end

    // pushed value is the return address past the current instruction
    always_ff @(posedge pclk) begin
        if (push) begin
            stack_mem[sp_q] <= pc_q + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_top_q <= '0;
        end else if (push) begin
            stack_top_q <= pc_q + 13'h0001;
        end else if (pop) begin
            stack_top_q <= stack_mem[SP_W'(sp_q - SP_W'(2))];
        end
    end

    // indirect data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b0;
        end else begin
            mem_addr_q <= {indirect_bank_select_q, file_pointer_q};
            mem_wdata_q <= pwdata[7:0];
            mem_we_q <= wr_acc && paddr == cfs_pkg::ADDR_INDIRECT && !ind_self;
            mem_re_q <= setup && !pwrite && paddr == cfs_pkg::ADDR_INDIRECT && !ind_self;
        end
    end

    // read mux, registered for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !mapped;
            case (paddr)
                cfs_pkg::ADDR_REQ_FLAGS: prdata_q <= {24'h000000, req_view};
                cfs_pkg::ADDR_POWER_CTL: prdata_q <= {24'h000000, power_control_status_q};
                cfs_pkg::ADDR_LATCH: prdata_q <= {27'h0000000, counter_high_latch_q};
                cfs_pkg::ADDR_PC_LOW: prdata_q <= {24'h000000, pc_q[7:0]};
                cfs_pkg::ADDR_POINTER: prdata_q <= {24'h000000, file_pointer_q};
                cfs_pkg::ADDR_INDIRECT: prdata_q <= {24'h000000,
                    ind_self ? cfs_pkg::INDIRECT_SELF : cfs_pkg::INDIRECT_NULL};
                cfs_pkg::ADDR_PC_FULL: prdata_q <= {19'h00000, pc_q};
                cfs_pkg::ADDR_STATUS_CTL: prdata_q <= {31'h00000000, indirect_bank_select_q};
                default: prdata_q <= cfs_pkg::UNMAPPED_DATA;
            endcase
        end else if (ind_wait_q) begin
            prdata_q <= {24'h000000, mem_rdata};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_we = mem_we_q;
    assign mem_re = mem_re_q;
    assign program_counter = pc_q;
    assign stack_top = stack_top_q;
    assign ultra_low_wake_enable = power_control_status_q[cfs_pkg::BIT_ULP_WAKE];
    assign brownout_detect_enable = bod_en_q;

    // enable trails config and soft bit by a cycle, traded for a flopped output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_en_q <= 1'b0;
        end else begin
            bod_en_q <= brownout_config_field == cfs_pkg::BOD_CFG_SOFT
                && power_control_status_q[cfs_pkg::BIT_SOFT_BOD];
        end
    end

    a_flag_held_set: assert property (@(posedge pclk) disable iff (!presetn)
        periph.timer_one_overflow |=> req_q[cfs_pkg::BIT_TMR1])
        else $error("timer flag not set");
    a_nv_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        periph.nv_write_done |=> req_q[cfs_pkg::BIT_NV_DONE])
        else $error("nv flag not set");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        req_q[cfs_pkg::BIT_OSC_FAIL] && !(psel && penable && pwrite) |=> req_q[cfs_pkg::BIT_OSC_FAIL])
        else $error("osc flag dropped");
    a_cmp_change_set: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(periph.cmp_one_out) |=> req_q[cfs_pkg::BIT_CMP1])
        else $error("comparator flag not set");
    a_jump_upper_bits: assert property (@(posedge pclk) disable iff (!presetn)
        flow_req.op == cfs_pkg::CFS_OP_JUMP && !pc_add_valid && !wr_acc
        |=> pc_q[12:11] == $past(counter_high_latch_q[4:3]))
        else $error("jump upper bits wrong");
    a_call_return_pair: assert property (@(posedge pclk) disable iff (!presetn)
        flow_req.op == cfs_pkg::CFS_OP_CALL && !pc_add_valid && !wr_acc ##1
        flow_req.op == cfs_pkg::CFS_OP_RETURN && !pc_add_valid && !wr_acc
        |=> pc_q == $past(pc_q, 2) + 13'h0001)
        else $error("return address mismatch");
    a_add_no_carry: assert property (@(posedge pclk) disable iff (!presetn)
        pc_add_valid && !wr_acc |=> pc_q[12:8] == $past(counter_high_latch_q))
        else $error("add carried into upper bits");
    a_por_clears: assert property (@(posedge pclk) disable iff (!presetn)
        power_on_event |=> !power_control_status_q[cfs_pkg::BIT_POR_STAT])
        else $error("power-on status not cleared");
    a_bod_clears: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_event |=> !power_control_status_q[cfs_pkg::BIT_BOD_STAT])
        else $error("brown-out status not cleared");
    a_ind_self_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
        ind_self |=> !mem_we_q)
        else $error("self indirect write stored");
    a_ind_self_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == cfs_pkg::ADDR_INDIRECT && ind_self
        |=> prdata_q[7:0] == cfs_pkg::INDIRECT_SELF)
        else $error("self indirect read not zero");
endmodule

// [verilog/cfs_pkg.sv]
// constants and carriers for the core flow and status register block
package cfs_pkg;
    // register byte addresses; 0x8E is not a multiple of four, so printed offsets are indices
    localparam logic [7:0] IDX_REQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_POWER_CTL = 8'h8E;
    localparam logic [11:0] ADDR_REQ_FLAGS = 12'h030;
    localparam logic [11:0] ADDR_POWER_CTL = 12'h238;
    // block-local registers
    localparam logic [11:0] ADDR_LATCH = 12'h400;
    localparam logic [11:0] ADDR_PC_LOW = 12'h404;
    localparam logic [11:0] ADDR_POINTER = 12'h408;
    localparam logic [11:0] ADDR_INDIRECT = 12'h40C;
    localparam logic [11:0] ADDR_PC_FULL = 12'h410;
    localparam logic [11:0] ADDR_STATUS_CTL = 12'h414;
    // request flag bit positions
    localparam int BIT_NV_DONE = 7;
    localparam int BIT_CONV_DONE = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_CMP2 = 4;
    localparam int BIT_CMP1 = 3;
    localparam int BIT_OSC_FAIL = 2;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_TMR1 = 0;
    localparam logic [7:0] REQ_SW_CLEAR_MASK = 8'hDD;
    // power control bit positions and reset value
    localparam int BIT_ULP_WAKE = 5;
    localparam int BIT_SOFT_BOD = 4;
    localparam int BIT_POR_STAT = 1;
    localparam int BIT_BOD_STAT = 0;
    localparam logic [7:0] POWER_CONTROL_STATUS_WMASK = 8'h33;
    localparam logic [7:0] POWER_CONTROL_STATUS_RESET = 8'h11;
    localparam logic [1:0] BOD_CFG_SOFT = 2'h1;
    localparam logic [7:0] REQ_RESET = 8'h00;
    localparam logic [7:0] INDIRECT_SELF = 8'h00;
    localparam logic [7:0] INDIRECT_NULL = 8'h00;
    // program flow
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        CFS_OP_NONE = 3'h0,
        CFS_OP_CALL = 3'h1,
        CFS_OP_JUMP = 3'h2,
        CFS_OP_RETURN = 3'h3,
        CFS_OP_RET_LIT = 3'h4,
        CFS_OP_RET_INT = 3'h5,
        CFS_OP_VECTOR = 3'h6,
        CFS_OP_STEP = 3'h7
    } cfs_op_t;

    typedef struct packed {
        cfs_op_t op;
        logic [10:0] target;
        logic [12:0] vector;
    } cfs_flow_req_t;

    typedef struct packed {
        logic nv_write_done;
        logic conversion_done;
        logic rx_has_data;
        logic cmp_two_out;
        logic cmp_one_out;
        logic osc_failed;
        logic tx_empty;
        logic timer_one_overflow;
    } cfs_periph_t;

    typedef enum logic [1:0] {
        CFS_ST_IDLE = 2'b00,
        CFS_ST_ACCESS = 2'b01
    } cfs_state_t;
endpackage
